// >>> src/converter_error_flags.sv
// Error flag bank with sample discard, error mask, interrupt and Wishbone slave.
`timescale 1ns/10ps

// Contract
// - Set bit 6 whenever a converter sample frame fails its integrity check.
// - Drop a failed sample and keep feeding that channel's last valid sample.
// - Set the rate fault flag when strobe rate differs from the expected 4 kHz.
// - Writing 1 to bit 8 clears the rate flag; it sets again if fault persists.
// - Converter reset while conversion runs also raises the rate fault flag.
// - Combined error output is the OR of all flags whose mask bits are set.
module converter_error_flags import err_flags_pkg::*; #(
  parameter int unsigned STROBE_PERIOD_CYC = STROBE_PERIOD_CYC_DEF
) (
  input wire logic clk_i, // System clock, 100 MHz.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [3:0] wb_adr_i, // Wishbone byte address.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  input wire logic [4:0] internal_fault_i, // Internal fault pulses a to e.
  input wire logic sample_strobe_i, // Sample-ready strobe.
  input wire logic conv_running_i, // Conversion is running.
  input wire logic conv_reset_i, // Converters are being reset.
  input wire logic sample_valid_i, // A sample frame arrives.
  input wire logic crc_ok_i, // Frame passed its integrity check.
  input wire sample_type sample_i, // Channel and data of the frame.
  output logic sample_valid_o, // Sample forwarded to measurement.
  output sample_type sample_o, // Forwarded channel and data.
  output logic combined_error_o, // Masked OR of error flags.
  output logic irq_o // Interrupt, active high level.
);

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] flags_reg;
  logic [31:0] err_mask_reg;
  logic [31:0] irq_status_reg;
  logic [31:0] irq_mask_reg;
  logic [DATA_W-1:0] held_reg [NUM_CHANNELS];
  logic [DATA_W-1:0] held_sel;
  logic rate_fault;
  logic chan_ok;
  logic crc_fail;
  logic [31:0] set_word;
  logic [31:0] wmask;
  logic bus_req;
  logic bus_wr;
  logic bus_rd;

  function automatic logic [31:0] sel_mask(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  assign chan_ok = 32'(sample_i.chan) < NUM_CHANNELS;
  assign held_sel = chan_ok ? held_reg[sample_i.chan] : '0;
  assign crc_fail = sample_valid_i & ~crc_ok_i;
  assign set_word = event_word(err_event_type'{internal_fault: internal_fault_i,
                                               sample_strobe_rate_fault: rate_fault, crc_fail: crc_fail});
  assign bus_req = wb_cyc_i & wb_stb_i;
  // Writes and read side effects land on the edge where the master sees ack.
  assign bus_wr = bus_req & wb_ack_o & wb_we_i;
  assign bus_rd = bus_req & wb_ack_o & ~wb_we_i;
  assign wmask = sel_mask(wb_sel_i);

  strobe_rate_monitor #(
    .PERIOD_CYC(STROBE_PERIOD_CYC)
  ) u_rate (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sample_strobe_i(sample_strobe_i),
    .conv_running_i(conv_running_i),
    .conv_reset_i(conv_reset_i),
    .fault_o(rate_fault)
  );

  ////////////////////////////////////////////////////////////////////////////
  // A new event in the clearing cycle wins, so no fault is ever lost.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_reg <= ERR_FLAGS_RST;
    end else if (bus_wr && wb_adr_i == OFS_ERR_FLAGS) begin
      flags_reg <= ((flags_reg & ~(wb_dat_i & wmask)) | set_word) & FLAGS_IMPL;
    end else begin
      flags_reg <= (flags_reg | set_word) & FLAGS_IMPL;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_mask_reg <= ERR_MASK_RST;
      irq_mask_reg <= IRQ_MASK_RST;
    end else if (bus_wr) begin
      if (wb_adr_i == OFS_ERR_MASK) begin
        err_mask_reg <= ((err_mask_reg & ~wmask) | (wb_dat_i & wmask)) & FLAGS_IMPL;
      end
      if (wb_adr_i == OFS_IRQ_MASK) begin
        irq_mask_reg <= ((irq_mask_reg & ~wmask) | (wb_dat_i & wmask)) & FLAGS_IMPL;
      end
    end
  end

  // The interrupt status copies each event and is cleared by reading it.
  // Only the bits that the read returned are cleared, because an event that lands
  // between latching the read data and the ack edge would otherwise be lost unseen.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status_reg <= READ_ZERO;
    end else if (bus_rd && wb_adr_i == OFS_IRQ_STATUS) begin
      irq_status_reg <= ((irq_status_reg & ~wb_dat_o) | set_word) & FLAGS_IMPL;
    end else begin
      irq_status_reg <= (irq_status_reg | set_word) & FLAGS_IMPL;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      combined_error_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      combined_error_o <= |(flags_reg & err_mask_reg);
      irq_o <= |(irq_status_reg & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Failed frames are replaced by the last good value, so the measurement paths
  // keep their cadence; a stuck link therefore freezes data rather than dropping it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        held_reg[i] <= '0;
      end
    end else if (sample_valid_i && crc_ok_i && chan_ok) begin
      held_reg[sample_i.chan] <= sample_i.data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_valid_o <= 1'b0;
      sample_o <= '0;
    end else begin
      sample_valid_o <= sample_valid_i & chan_ok;
      if (sample_valid_i && chan_ok) begin
        sample_o.chan <= sample_i.chan;
        sample_o.data <= crc_ok_i ? sample_i.data : held_sel;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= READ_ZERO;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      if (bus_req && !wb_ack_o && !wb_we_i) begin
        unique case (wb_adr_i)
          OFS_ERR_FLAGS: wb_dat_o <= flags_reg;
          OFS_ERR_MASK: wb_dat_o <= err_mask_reg;
          OFS_IRQ_STATUS: wb_dat_o <= irq_status_reg;
          OFS_IRQ_MASK: wb_dat_o <= irq_mask_reg;
          default: wb_dat_o <= READ_ZERO;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_bad_frame;
    sample_valid_i && !crc_ok_i;
  endsequence

  sequence s_w1c_rate;
    bus_wr && wb_adr_i == OFS_ERR_FLAGS && wb_sel_i[1] && wb_dat_i[BIT_RATE];
  endsequence

  property p_crc_flag;
    @(posedge clk_i) disable iff (rst_i) s_bad_frame |=> flags_reg[BIT_CRC];
  endproperty
  a_crc_flag: assert property (p_crc_flag) else $error("crc flag not set");

  property p_hold_sample;
    @(posedge clk_i) disable iff (rst_i)
      (s_bad_frame and chan_ok) |=> sample_valid_o && sample_o.data == $past(held_sel);
  endproperty
  a_hold_sample: assert property (p_hold_sample) else $error("failed sample not replaced");

  property p_rate_flag;
    @(posedge clk_i) disable iff (rst_i) rate_fault |=> flags_reg[BIT_RATE];
  endproperty
  a_rate_flag: assert property (p_rate_flag) else $error("rate flag not set");

  property p_w1c_clear;
    @(posedge clk_i) disable iff (rst_i) (s_w1c_rate and !rate_fault) |=> !flags_reg[BIT_RATE];
  endproperty
  a_w1c_clear: assert property (p_w1c_clear) else $error("write one did not clear");

  property p_set_wins;
    @(posedge clk_i) disable iff (rst_i) (s_w1c_rate and rate_fault) |=> flags_reg[BIT_RATE];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("persisting fault lost");

  property p_sticky;
    @(posedge clk_i) disable iff (rst_i)
      (flags_reg[BIT_CRC] && !(bus_wr && wb_adr_i == OFS_ERR_FLAGS)) |=> flags_reg[BIT_CRC];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without write");

  property p_combined;
    @(posedge clk_i) disable iff (rst_i)
      ##1 combined_error_o == |($past(flags_reg) & $past(err_mask_reg));
  endproperty
  a_combined: assert property (p_combined) else $error("combined error mismatch");

  property p_ack_single;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_single: assert property (p_ack_single) else $error("ack held too long");

endmodule

// >>> src/err_flags_pkg.sv
// Shared constants and types for the converter error flag bank.
package err_flags_pkg;

  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int unsigned STROBE_RATE_HZ = 4_000;
  localparam int unsigned STROBE_PERIOD_CYC_DEF = CLK_FREQ_HZ / STROBE_RATE_HZ;
  localparam int unsigned STROBE_TOL_PCT = 1;
  localparam int unsigned STROBE_CNT_W = 16;

  localparam int unsigned NUM_CHANNELS = 12;
  localparam int unsigned CHAN_W = 4;
  localparam int unsigned DATA_W = 24;

  localparam logic [3:0] OFS_ERR_FLAGS = 4'h0;
  localparam logic [3:0] OFS_ERR_MASK = 4'h4;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h8;
  localparam logic [3:0] OFS_IRQ_MASK = 4'hC;

  localparam int unsigned BIT_FAULT_A = 2;
  localparam int unsigned BIT_FAULT_B = 3;
  localparam int unsigned BIT_FAULT_C = 4;
  localparam int unsigned BIT_FAULT_D = 5;
  localparam int unsigned BIT_CRC = 6;
  localparam int unsigned BIT_FAULT_E = 7;
  localparam int unsigned BIT_RATE = 8;

  localparam logic [31:0] FLAGS_IMPL = 32'h0000_01FC;
  localparam logic [31:0] ERR_FLAGS_RST = 32'h0000_0000;
  localparam logic [31:0] ERR_MASK_RST = 32'h0000_0000;
  localparam logic [31:0] IRQ_MASK_RST = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic [DATA_W-1:0] data;
  } sample_type;

  typedef struct packed {
    logic [4:0] internal_fault;
    logic sample_strobe_rate_fault;
    logic crc_fail;
  } err_event_type;

  // Places the five internal faults and the two converter events at their bit positions.
  function automatic logic [31:0] event_word(input err_event_type ev);
    logic [31:0] w;
    w = READ_ZERO;
    w[BIT_FAULT_A] = ev.internal_fault[0];
    w[BIT_FAULT_B] = ev.internal_fault[1];
    w[BIT_FAULT_C] = ev.internal_fault[2];
    w[BIT_FAULT_D] = ev.internal_fault[3];
    w[BIT_FAULT_E] = ev.internal_fault[4];
    w[BIT_CRC] = ev.crc_fail;
    w[BIT_RATE] = ev.sample_strobe_rate_fault;
    return w;
  endfunction

endpackage

// >>> src/strobe_rate_monitor.sv
// Measures the spacing of sample-ready strobe edges and reports rate faults.
`timescale 1ns/10ps
module strobe_rate_monitor import err_flags_pkg::*; #(
  parameter int unsigned PERIOD_CYC = STROBE_PERIOD_CYC_DEF
) (
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic sample_strobe_i, // Sample-ready strobe from converters.
  input wire logic conv_running_i, // Conversion is running.
  input wire logic conv_reset_i, // Converters are being reset.
  output logic fault_o // Rate fault: one-cycle pulse per spacing fault, held high while converters reset during conversion.
);

  localparam int unsigned TOL_CYC = (PERIOD_CYC * STROBE_TOL_PCT + 99) / 100;
  localparam logic [STROBE_CNT_W-1:0] LO_CYC = STROBE_CNT_W'(PERIOD_CYC - TOL_CYC);
  localparam logic [STROBE_CNT_W-1:0] HI_CYC = STROBE_CNT_W'(PERIOD_CYC + TOL_CYC);

  logic strobe_d_reg;
  logic armed_reg;
  logic [STROBE_CNT_W-1:0] count_reg;
  logic rise;
  logic bad_spacing;
  logic timeout;

  assign rise = sample_strobe_i & ~strobe_d_reg;
  assign bad_spacing = armed_reg & rise & ((count_reg < LO_CYC) | (count_reg > HI_CYC));
  assign timeout = armed_reg & ~rise & (count_reg == HI_CYC);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strobe_d_reg <= 1'b0;
    end else begin
      strobe_d_reg <= sample_strobe_i;
    end
  end

  // A missing edge is reported once, then the monitor rearms on the next edge.
  always_ff @(posedge clk_i) begin
    if (rst_i || !conv_running_i) begin
      armed_reg <= 1'b0;
      count_reg <= '0;
    end else if (rise) begin
      armed_reg <= 1'b1;
      count_reg <= STROBE_CNT_W'(1);
    end else if (timeout) begin
      armed_reg <= 1'b0;
    end else if (count_reg != HI_CYC) begin
      count_reg <= count_reg + STROBE_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_o <= 1'b0;
    end else begin
      fault_o <= bad_spacing | timeout | (conv_reset_i & conv_running_i);
    end
  end

  property p_rate_timeout;
    @(posedge clk_i) disable iff (rst_i) timeout |=> fault_o;
  endproperty
  a_rate_timeout: assert property (p_rate_timeout) else $error("missing strobe not reported");

  property p_rate_short;
    @(posedge clk_i) disable iff (rst_i) (armed_reg && rise && count_reg < LO_CYC) |=> fault_o;
  endproperty
  a_rate_short: assert property (p_rate_short) else $error("early strobe not reported");

  property p_reset_running;
    @(posedge clk_i) disable iff (rst_i) (conv_reset_i && conv_running_i) |=> fault_o;
  endproperty
  a_reset_running: assert property (p_reset_running) else $error("converter reset not reported");

  property p_no_false_fault;
    @(posedge clk_i) disable iff (rst_i)
      (!conv_reset_i && !timeout && !bad_spacing) |=> !fault_o;
  endproperty
  a_no_false_fault: assert property (p_no_false_fault) else $error("rate fault without cause");

endmodule

// >>> testbench/converter_error_flags_test.sv
// Self-checking bench for the converter error flag bank.
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); err_total++; end end
module converter_error_flags_test import err_flags_pkg::*;;
  localparam int unsigned PER = 200;
  // Allowed strobe spacing deviation: one percent of the period, rounded up.
  localparam int unsigned TOL = (PER * STROBE_TOL_PCT + 99) / 100;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, strobe = 0, run = 0, creset = 0, sv = 0, ok = 0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rd, dat_o, m;
  logic [4:0] fault = 5'h00, v;
  logic ack, sv_o, comb, irq, bad, gd;
  sample_type smp = '0, smp_o;
  logic [DATA_W-1:0] last [NUM_CHANNELS];
  int err_total = 0, n_tests = 0, seed = 32'h1f59, c;
  converter_error_flags #(.STROBE_PERIOD_CYC(PER)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .internal_fault_i(fault), .sample_strobe_i(strobe), .conv_running_i(run),
    .conv_reset_i(creset), .sample_valid_i(sv), .crc_ok_i(ok), .sample_i(smp), .sample_valid_o(sv_o),
    .sample_o(smp_o), .combined_error_o(comb), .irq_o(irq));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Places the five internal fault events at their flag positions.
  function automatic logic [31:0] fw(input logic [4:0] f);
    return {23'h00_0000, 1'b0, f[4], 1'b0, f[3:0], 2'b00};
  endfunction
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Holds the request until ack is sampled, then releases for one idle cycle.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic pulse_fault(input logic [4:0] f);
    fault <= f;
    @(posedge clk_i);
    fault <= 5'h00;
    repeat (3) @(posedge clk_i);
  endtask
  // Rising strobe edges spaced gap cycles apart.
  task automatic edges(input int n, input int gap);
    repeat (n) begin
      strobe <= 1'b1;
      @(posedge clk_i);
      strobe <= 1'b0;
      repeat (gap - 1) @(posedge clk_i);
    end
  endtask
  task automatic send(input int ch, input logic [DATA_W-1:0] d, input logic good);
    sv <= 1'b1;
    ok <= good;
    smp <= {ch[CHAN_W-1:0], d};
    @(posedge clk_i);
    sv <= 1'b0;
    @(posedge clk_i);
    if (good) last[ch] = d;
  endtask
  initial begin
    repeat (20_000) @(posedge clk_i);
    err_total++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    foreach (last[i]) last[i] = '0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 0; a < 16; a += 4) begin
      wb(1'b0, a[3:0], 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
    end
    // Random internal faults: set, survive a write of zero, clear on a write of one.
    repeat (8) begin
      v = 5'($random(seed));
      if (v == 5'h00) v = 5'h11;
      pulse_fault(v);
      wb(1'b0, OFS_ERR_FLAGS, 32'h0000_0000);
      `CHK(rd, fw(v))
      wb(1'b1, OFS_ERR_FLAGS, ~fw(v));
      wb(1'b0, OFS_ERR_FLAGS, 32'h0000_0000);
      `CHK(rd, fw(v))
      m = 32'($random(seed)) & 32'h0000_01FC;
      wb(1'b1, OFS_ERR_MASK, m);
      repeat (3) @(posedge clk_i);
      `CHK(comb, |(fw(v) & m))
      wb(1'b1, OFS_ERR_FLAGS, fw(v));
      wb(1'b0, OFS_ERR_FLAGS, 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
    end
    // Samples with random integrity results; failed ones keep the last good value.
    wb(1'b1, OFS_ERR_MASK, 32'h0000_0040);
    bad = 1'b0;
    for (int i = 0; i < 16; i++) begin
      c = i == 5 ? 11 : ($unsigned($random(seed)) % NUM_CHANNELS);
      gd = ($random(seed) & 1) != 0 && i != 5;
      bad = bad | !gd;
      send(c, DATA_W'($random(seed)), gd);
      `CHK(sv_o, 1'b1)
      `CHK(smp_o.chan, c[CHAN_W-1:0])
      `CHK(smp_o.data, last[c])
    end
    // A channel beyond the last one is dropped, yet its failed check still counts.
    send(13, DATA_W'($random(seed)), 1'b0);
    `CHK(sv_o, 1'b0)
    wb(1'b0, OFS_ERR_FLAGS, 32'h0000_0000);
    `CHK(rd[BIT_CRC], bad)
    repeat (2) @(posedge clk_i);
    `CHK(comb, 1'b1)
    wb(1'b1, OFS_ERR_FLAGS, 32'hFFFF_FFFF);
    // Strobe spacing at the edges of tolerance, then far off.
    run <= 1'b1;
    edges(1, PER);
    edges(1, PER - TOL);
    edges(1, PER + TOL);
    edges(1, 1);
    run <= 1'b0;
    wb(1'b0, OFS_ERR_FLAGS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    run <= 1'b1;
    edges(2, PER);
    edges(2, PER - 50);
    run <= 1'b0;
    wb(1'b0, OFS_ERR_FLAGS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0100)
    wb(1'b1, OFS_ERR_FLAGS, 32'h0000_0100);
    wb(1'b0, OFS_ERR_FLAGS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    // A strobe that stops while conversion runs is reported once.
    run <= 1'b1;
    edges(1, PER + TOL + 4);
    run <= 1'b0;
    wb(1'b0, OFS_ERR_FLAGS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0100)
    wb(1'b1, OFS_ERR_FLAGS, 32'h0000_0100);
    // Converter reset during conversion; the flag returns while it persists.
    run <= 1'b1;
    creset <= 1'b1;
    wb(1'b1, OFS_ERR_FLAGS, 32'h0000_0100);
    wb(1'b0, OFS_ERR_FLAGS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0100)
    run <= 1'b0;
    creset <= 1'b0;
    repeat (3) @(posedge clk_i);
    wb(1'b1, OFS_ERR_FLAGS, 32'h0000_0100);
    wb(1'b0, OFS_ERR_FLAGS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    // Interrupt: raised when unmasked, cleared by reading status, silent when masked.
    wb(1'b1, OFS_IRQ_MASK, 32'h0000_0004);
    wb(1'b0, OFS_IRQ_STATUS, 32'h0000_0000);
    repeat (2) @(posedge clk_i);
    `CHK(irq, 1'b0)
    pulse_fault(5'h01);
    `CHK(irq, 1'b1)
    wb(1'b0, OFS_IRQ_STATUS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0004)
    repeat (2) @(posedge clk_i);
    `CHK(irq, 1'b0)
    wb(1'b1, OFS_IRQ_MASK, 32'h0000_0000);
    pulse_fault(5'h01);
    `CHK(irq, 1'b0)
    wb(1'b0, OFS_IRQ_STATUS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0004)
    // Recurring failed frames and internal faults: software resets device and converters, then restarts.
    repeat (3) send(0, DATA_W'($random(seed)), 1'b0);
    pulse_fault(5'h1F);
    rst_i <= 1'b1;
    creset <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    creset <= 1'b0;
    foreach (last[i]) last[i] = '0;
    @(posedge clk_i);
    `CHK({comb, irq, sv_o, ack}, 4'h0)
    for (int a = 0; a < 16; a += 4) begin
      wb(1'b0, a[3:0], 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
    end
    run <= 1'b1;
    edges(3, PER);
    run <= 1'b0;
    send(0, DATA_W'($random(seed)), 1'b0);
    `CHK(smp_o.data, last[0])
    wb(1'b0, OFS_ERR_FLAGS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0040)
    test_done();
  end
endmodule
